/* File: bench/relay_contacts.sv */
// Purpose: external circuit on the relay contacts
// Assumes: ideal contacts. Notes: no bounce modelled
module relay_contacts (
  input wire logic relay_drive,
  output logic contact_closed
);
  timeunit 1ns;
  timeprecision 1ns;
  assign contact_closed = relay_drive;
endmodule // relay_contacts

/* File: bench/relay_out_properties.sv */
// Purpose: port checks for the relay output block
// Assumes: selection 7 at reset. Notes: state outputs lag their cause one edge, zero-delay timed outputs two
module relay_out_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sel_write,
  input wire logic [4:0] sel_wdata,
  input wire logic factory_load,
  input wire logic [9:0] output_delay_seconds,
  input wire relay_out_pkg::events_s events,
  input wire relay_out_pkg::status_s status,
  input wire logic [4:0] fault_code,
  input wire logic [4:0] output_function_select,
  input wire logic relay_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] sel;
  logic mf;
  assign sel = output_function_select;
  assign mf = fault_code inside {5'h05, 5'h06, 5'h07, 5'h08, 5'h0C, 5'h0F};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence zero_trig;
    sel == 5'h00 && output_delay_seconds == 10'h000 && events.start_cmd;
  endsequence
  load_default_a: assert property (factory_load |=> sel == 5'h07)
    else $error("load did not give 7");
  write_takes_a: assert property (sel_write && !factory_load &&
    sel_wdata <= 5'h13 |=> sel == $past(sel_wdata)) else $error("lost write");
  bad_write_a: assert property (sel_write && !factory_load &&
    sel_wdata > 5'h13 |=>
    $stable(sel)) else $error("bad value taken");
  ready_mirror_a: assert property (sel == 5'h07 |=>
    relay_drive == $past(status.ready)) else $error("ready not shown");
  ready_invert_a: assert property (sel == 5'h11 |=>
    relay_drive != $past(status.ready)) else $error("not inverted");
  running_mirror_a: assert property (sel == 5'h06 |=> relay_drive ==
    (!$past(status.ready) && !$past(status.fault))) else $error("run");
  motor_fault_a: assert property (sel == 5'h05 |=>
    relay_drive == $past(mf)) else $error("motor fault wrong");
  zero_delay_a: assert property (zero_trig |-> ##[1:2] relay_drive)
    else $error("zero delay late");
endmodule // relay_out_properties
bind relay_out_ctrl relay_out_properties PROPS (.mclk, .rst_n, .sel_write,
  .sel_wdata, .factory_load, .output_delay_seconds, .events, .status,
  .fault_code, .output_function_select, .relay_drive);

/* File: bench/tb_programmable_relay_output_control.sv */
// Purpose: bench for relay output control
// Assumes: tick of 10 cycles. Notes: inputs change on falling edge
module tb_programmable_relay_output_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, sel_write = 0, factory_load = 0, closed, rd;
  logic [4:0] sel_wdata = 5'h00, fault_code = 5'h00, ofs;
  logic [9:0] dly = 10'h000;
  relay_out_pkg::events_s ev = '0;
  relay_out_pkg::status_s st = 4'h8;
  relay_out_pkg::status_s pat [3] = '{4'h8, 4'h5, 4'h2};
  logic [4:0] fc [3] = '{5'h00, 5'h0C, 5'h00};
  logic [2:0] tbl [5] = '{3'h2, 3'h4, 3'h1, 3'h2, 3'h4};
  int failures = 0, n_compared = 0, cyc = 0;
  always #50 mclk = ~mclk;
  relay_out_ctrl #(.TICK_CYCLES(10)) DUT (.mclk, .rst_n, .sel_write,
    .sel_wdata, .factory_load, .output_delay_seconds(dly), .events(ev),
    .status(st), .fault_code, .output_function_select(ofs), .relay_drive(rd));
  relay_contacts PARTNER (.relay_drive(rd), .contact_closed(closed));
  task automatic chk(input logic [4:0] got, input logic [4:0] exp, string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [4:0] v);
    sel_wdata = v;
    sel_write = 1'b1;
    @(negedge mclk);
    sel_write = 1'b0;
  endtask
  task automatic go(input logic [4:0] e);
    ev = e;
    @(negedge mclk);
    ev = '0;
  endtask
  task automatic t_sel;
    chk(ofs, 5'h07, "default");
    wr(5'h14);
    chk(ofs, 5'h07, "range");
    wr(5'h13);
    chk(ofs, 5'h13, "write");
    factory_load = 1'b1;
    @(negedge mclk);
    factory_load = 1'b0;
    chk(ofs, 5'h07, "load");
    $display("t_sel done");
  endtask
  task automatic t_state;
    dly = 10'h005;
    for (int k = 0; k < 10; k++) begin
      wr(5'(k % 5 + 5 + (k / 5) * 10));
      for (int j = 0; j < 3; j++) begin
        st = pat[j];
        fault_code = fc[j];
        repeat (2) @(negedge mclk);
        chk({4'h0, closed}, {4'h0, tbl[k % 5][j] ^ (k > 4)}, "state");
      end
    end
    $display("t_state done");
  endtask
  task automatic t_timed;
    st = 4'h8;
    dly = 10'h000;
    for (int i = 0; i < 5; i++) begin
      wr(5'(i));
      go(5'h10 >> i);
      repeat (2) @(negedge mclk);
      chk({4'h0, closed}, 5'h01, "fire");
      repeat (40) @(negedge mclk);
      chk({4'h0, closed}, 5'h00, "release");
    end
    // Not ready: the changed output must stand until ready returns
    wr(5'h0A);
    st = 4'h4;
    dly = 10'h003;
    go(5'h10);
    repeat (16) @(negedge mclk);
    go(5'h10);
    repeat (16) @(negedge mclk);
    chk({4'h0, closed}, 5'h01, "abort");
    repeat (20) @(negedge mclk);
    chk({4'h0, closed}, 5'h00, "delay");
    st = 4'h8;
    repeat (30) @(negedge mclk);
    chk({4'h0, closed}, 5'h01, "hold");
    $display("t_timed done");
  endtask
  task automatic report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(negedge mclk);
    chk({4'h0, closed}, 5'h00, "reset");
    @(negedge mclk);
    rst_n = 1'b1;
    t_sel();
    t_state();
    t_timed();
    report_and_stop();
  end
endmodule // tb_programmable_relay_output_control

/* File: rtl/relay_out_ctrl.sv */
// Purpose: programmable relay output, timed and state modes
// Assumes: events are one-cycle pulses on mclk; status levels on mclk
// Notes: fault code is the starter's latest fault number, 0 for none
`include "relay_out_map.svh"

// What this block does
// - Selections 0-4 and 10-14 are timed, on five start/stop events.
// - Timed mode waits up to 999 s; zero delay acts at once.
// - Changed output held until the next 1 s tick, then reset level when starter ready.
// - A new motor start aborts timing and restarts the sequence.
// - Selections 5-9 and 15-19 follow fault, run, ready, start, bypass.
// - State mode ignores the delay setting.
// - Factory default load sets the selection to 7.
// - Motor fault indication only for faults 05,06,07,08,12,15.
// - Running means neither ready nor faulted.
// - Selections above 9 invert the relay output.
// - Selection accepts only values 0 to 19.
module relay_out_ctrl #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sel_write,
  input wire logic [4:0] sel_wdata,
  input wire logic factory_load,
  input wire logic [9:0] output_delay_seconds,
  input wire relay_out_pkg::events_s events,
  input wire relay_out_pkg::status_s status,
  input wire logic [4:0] fault_code,
  output logic [4:0] output_function_select,
  output logic relay_drive
);
  logic [4:0] sel_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [9:0] sec_reg;
  relay_out_pkg::timer_e tstate_reg;
  logic [4:0] base;
  logic inv;
  logic timed;
  logic trig;
  logic motor_fault;
  logic state_out;
  logic active;
  logic relay_next;
  logic abort;
  logic delay_done;
  logic hold_done;

  // A start that is not itself the trigger cancels the running cycle
  assign abort = events.start_cmd && (base != 5'h00);

  // Saturate at the longest legal delay even if a larger value is applied
  assign delay_done = tick &&
                      (sec_reg + 10'h1 >= output_delay_seconds ||
                       sec_reg + 10'h1 >= `DELAY_MAX_S);

  // Hold is finished once one tick has been counted
  assign hold_done = (sec_reg >= `HOLD_S);

  // Out-of-range writes are dropped so the mode stays decodable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= `SEL_DEFAULT;
    end else if (factory_load) begin
      sel_reg <= `SEL_DEFAULT;
    end else if (sel_write && sel_wdata <= `SEL_MAX) begin
      sel_reg <= sel_wdata;
    end
  end
  assign output_function_select = sel_reg;

  assign inv = (sel_reg >= `SEL_INVERT_MIN);
  assign base = inv ? sel_reg - `SEL_INVERT_MIN : sel_reg;
  assign timed = (base < `SEL_STATE_MIN);

  always_comb begin
    case (base)
      5'h00: trig = events.start_cmd;
      5'h01: trig = events.ramp_start;
      5'h02: trig = events.bypass_on;
      5'h03: trig = events.stop_cmd;
      5'h04: trig = events.stop_done;
      default: trig = 1'b0;
    endcase
  end

  // Free-running tick; a restart does not realign it, so delays run up to 1 s short
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 32'h0;
    end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tstate_reg <= relay_out_pkg::ST_IDLE;
      sec_reg <= 10'h0;
    end else if (!timed) begin
      tstate_reg <= relay_out_pkg::ST_IDLE;
      sec_reg <= 10'h0;
    end else if (abort) begin
      tstate_reg <= relay_out_pkg::ST_IDLE;
      sec_reg <= 10'h0;
    end else if (trig) begin
      sec_reg <= 10'h0;
      if (output_delay_seconds == 10'h0) begin
        tstate_reg <= relay_out_pkg::ST_HOLD;
      end else begin
        tstate_reg <= relay_out_pkg::ST_DELAY;
      end
    end else begin
      case (tstate_reg)
        relay_out_pkg::ST_DELAY: begin
          if (delay_done) begin
            tstate_reg <= relay_out_pkg::ST_HOLD;
            sec_reg <= 10'h0;
          end else if (tick) begin
            sec_reg <= sec_reg + 10'h1;
          end
        end
        relay_out_pkg::ST_HOLD: begin
          if (hold_done) begin
            if (status.ready) begin
              tstate_reg <= relay_out_pkg::ST_IDLE;
              sec_reg <= 10'h0;
            end
          end else if (tick) begin
            sec_reg <= sec_reg + 10'h1;
          end
        end
        default: begin
          sec_reg <= 10'h0;
        end
      endcase
    end
  end

  always_comb begin
    case (fault_code)
      5'h05, 5'h06, 5'h07, 5'h08, 5'h0C, 5'h0F: motor_fault = 1'b1;
      default: motor_fault = 1'b0;
    endcase
  end

  // Delay setting is never read on this path
  always_comb begin
    case (base)
      5'h05: state_out = motor_fault;
      5'h06: state_out = !status.ready && !status.fault;
      5'h07: state_out = status.ready;
      5'h08: state_out = status.starting;
      5'h09: state_out = status.bypass;
      default: state_out = 1'b0;
    endcase
  end

  assign active = timed ? (tstate_reg == relay_out_pkg::ST_HOLD) : state_out;
  assign relay_next = active ^ inv;

  // Reset level is open; inverted timed selections settle closed one edge later
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      relay_drive <= 1'b0;
    end else begin
      relay_drive <= relay_next;
    end
  end
endmodule // relay_out_ctrl

/* File: rtl/relay_out_map.svh */
// Purpose: constants for the programmable relay output block
// Assumes: 10 MHz mclk
// Notes: definitions only
`ifndef RELAY_OUT_MAP_SVH
`define RELAY_OUT_MAP_SVH
`define SEL_DEFAULT 5'h07
`define SEL_MAX 5'h13
`define SEL_INVERT_MIN 5'h0A
`define SEL_STATE_MIN 5'h05
`define DELAY_MAX_S 10'h3E7
`define HOLD_S 10'h001
`define CLK_HZ 10000000
`define TICK_CYCLES (`CLK_HZ * 1)
`endif

/* File: rtl/relay_out_pkg.sv */
// Purpose: types for the programmable relay output block
// Assumes: nothing
// Notes: event and status bundles
package relay_out_pkg;
  typedef struct packed {
    logic start_cmd;
    logic ramp_start;
    logic bypass_on;
    logic stop_cmd;
    logic stop_done;
  } events_s;
  typedef struct packed {
    logic ready;
    logic starting;
    logic bypass;
    logic fault;
  } status_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_HOLD = 2'b10
  } timer_e;
endpackage
